// ---- rtl/rms_reset_mode_sequencer.sv ----
`timescale 1ns/1ps
// Overview of operation
// - decode select pins into four operating modes
// - slow clock from oscillator, bypass uses osc_input
// - core runs on master or slow clock
// - clock output copies slow clock until reprogrammed
// - reset defaults peripherals, fetch from zero
// - only program counter has reset value
// - external bus address low during reset
// - peripheral clocks gated off during reset
// - reset asserts at once, releases on slow clock
// - straps sampled in last ten slow cycles
// - hardware reset never touches emulation logic
// - tap reset goes to captured tap choice
// - watchdog reset keeps latched strap values
// - coincident resets count as hardware reset
// - tristate mode floats all output drivers
// - emulation selected when high select pin low
// - scan mode decodes sample, extest, bypass
// - emulation mode answers with core id code
// - peripheral pins are inputs after reset
// - boot width one is 8 bit, zero 16
module rms_reset_mode_sequencer (
   input wire logic clock, // system clock, 10 MHz
   input wire logic rstn, // synchronous reset, low
   input wire logic ce, // clock enable, freezes all state
   input wire logic hw_reset_n, // hardware reset pin, low
   input wire logic watchdog_reset, // watchdog reset request, high
   input wire logic op_select_lo, // first mode select pin
   input wire logic op_select_hi, // second mode select pin
   input wire logic osc_clock, // on-chip 32.768 kHz oscillator level
   input wire logic osc_input, // oscillator input pin level
   input wire logic master_clock, // pll master clock level
   input wire logic core_on_slow, // software: run core on slow clock
   input wire logic clock_out_as_gpio, // software: clock pin is gpio
   input wire logic clock_out_gpio_level, // gpio value for clock pin
   input wire logic boot_width_select, // boot width strap
   input wire logic tristate_request_n, // tristate strap, low
   input wire logic tap_reset_n, // tap reset pin, low
   input wire logic tap_choice, // tap selection pin, high picks scan
   input wire logic [3:0] scan_instr, // current tap instruction
   output logic slow_clock, // selected slow clock level
   output logic core_clock, // core clock level
   output logic clock_out_pin, // clock output pin level
   output logic pc_reset_n, // clears program counter only, low
   output logic periph_reset_n, // peripheral register reset, low
   output logic fetch_from_zero, // force next fetch to address zero
   output logic ext_address_low, // force external bus address low
   output logic periph_clock_en, // peripheral clock enable
   output logic pio_all_input, // force peripheral pins to input
   output rms_pkg::rms_mode_type op_mode, // latched operating mode
   output logic boot_width_8bit, // latched boot width, 1 is 8 bit
   output logic tristate_mode, // latched tristate mode
   output logic outputs_hiz, // float every output driver
   output logic strap_unstable, // straps changed inside window
   output logic reset_too_short, // reset shorter than window
   output logic ice_select, // debug port in emulation mode
   output logic ice_reset_n, // emulation tap reset, low
   output logic scan_reset_n, // boundary scan tap reset, low
   output logic scan_sample, // scan sample instruction active
   output logic scan_extest, // scan extest instruction active
   output logic scan_bypass, // scan bypass instruction active
   output logic [31:0] tap_id_code // identification word for tap
);
   import rms_pkg::*;

   // sequencer state and watchdog hold count
   rms_state_type state;
   rms_state_type next_state;
   logic [3:0] wd_count;
   logic [3:0] next_wd_count;

   // slow clock edge and strap window
   logic slow_prev;
   logic slow_tick;
   logic window_full;
   logic [STRAP_COUNT-1:0] strap_sample;
   logic [STRAP_COUNT-1:0] strap_stable;
   logic strap_hold;
   logic hw_release;

   // clock source selection
   logic bypass_osc;
   logic next_slow_clock;

   // latched configuration
   logic tap_choice_l;
   logic next_tap_choice_l;
   rms_mode_type next_op_mode;
   logic next_boot_width_8bit;
   logic next_tristate_mode;
   logic next_strap_unstable;
   logic next_reset_too_short;

   // high while any reset holds the chip
   logic in_reset;

   // live pins steer bypass until release, latched mode after, so the
   // sync wait already ticks on the new source
   assign bypass_osc = (state == RMS_ST_HW || state == RMS_ST_SYNC) ?
      (rms_decode(op_select_lo, op_select_hi) == RMS_MODE_EXT) :
      (op_mode == RMS_MODE_EXT);
   assign next_slow_clock = bypass_osc ? osc_input : osc_clock;
   // tick lags the slow rise by one system cycle
   assign slow_tick = slow_clock && !slow_prev;
   assign strap_hold = (state == RMS_ST_HW) && !hw_reset_n;
   assign hw_release = (state == RMS_ST_HW) && hw_reset_n;

   // straps shift in on each slow tick while the pin is low
   rms_strap_window u_window (
      .clock(clock),
      .rstn(rstn),
      .ce(ce),
      .slow_tick(slow_tick),
      .hold(strap_hold),
      .strap({!tristate_request_n, boot_width_select}),
      .window_full(window_full),
      .sample(strap_sample),
      .stable(strap_stable)
   );

   // sequencer: pin low enters reset on the next edge, release waits for
   // a slow tick so the core leaves reset aligned to the slow clock
   always_comb begin
      next_state = state;
      next_wd_count = wd_count;
      case (state)
         RMS_ST_RUN: begin
            if (!hw_reset_n) begin
               next_state = RMS_ST_HW;
            end else if (watchdog_reset) begin
               next_state = RMS_ST_WD;
               next_wd_count = 4'h0;
            end
         end

         RMS_ST_HW: begin
            // held here for as long as the pin is low
            if (hw_reset_n) begin
               next_state = RMS_ST_SYNC;
            end
         end

         RMS_ST_SYNC: begin
            if (!hw_reset_n) begin
               next_state = RMS_ST_HW;
            end else if (slow_tick) begin
               next_state = RMS_ST_RUN;
            end
         end

         RMS_ST_WD: begin
            // pin reset keeps priority during the hold
            if (!hw_reset_n) begin
               next_state = RMS_ST_HW;
            end else if (slow_tick) begin
               if (wd_count == WD_HOLD_TICKS - 4'h1) begin
                  next_state = RMS_ST_RUN;
               end else begin
                  next_wd_count = wd_count + 4'h1;
               end
            end
         end

         default: begin
            // illegal codes recover by a full reset
            next_state = RMS_ST_HW;
         end
      endcase
   end

   // latched configuration; only the pin path touches the straps, so a
   // watchdog reset leaves boot width and tristate as they were
   always_comb begin
      next_op_mode = op_mode;
      next_boot_width_8bit = boot_width_8bit;
      next_tristate_mode = tristate_mode;
      next_strap_unstable = strap_unstable;
      next_reset_too_short = reset_too_short;
      next_tap_choice_l = tap_choice_l;
      // straps taken once, as the pin rises
      if (hw_release) begin
         next_boot_width_8bit = strap_sample[STRAP_BOOT];
         next_tristate_mode = strap_sample[STRAP_TRI];
         next_strap_unstable = !(&strap_stable);
         next_reset_too_short = !window_full;
      end
      // mode and tap choice move on the release edge
      if (state == RMS_ST_SYNC && hw_reset_n && slow_tick) begin
         next_op_mode = rms_decode(op_select_lo, op_select_hi);
         next_tap_choice_l = tap_choice;
      end
   end

   // outputs follow the next state so they line up with the transition
   assign in_reset = (next_state != RMS_ST_RUN);

   // state flops; a low ce freezes every one
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state <= RMS_ST_HW;
         wd_count <= 4'h0;
         slow_prev <= 1'b0;
         slow_clock <= 1'b0;
         op_mode <= MODE_RESET;
         boot_width_8bit <= BOOT_WIDTH_RESET;
         tristate_mode <= TRISTATE_RESET;
         strap_unstable <= 1'b0;
         reset_too_short <= 1'b0;
         tap_choice_l <= TAP_CHOICE_RESET;
      end else if (ce) begin
         state <= next_state;
         wd_count <= next_wd_count;
         slow_prev <= slow_clock;
         slow_clock <= next_slow_clock;
         op_mode <= next_op_mode;
         boot_width_8bit <= next_boot_width_8bit;
         tristate_mode <= next_tristate_mode;
         strap_unstable <= next_strap_unstable;
         reset_too_short <= next_reset_too_short;
         tap_choice_l <= next_tap_choice_l;
      end
   end

   // output group: reset side effects, clocks and tap steering
   logic next_core_clock;
   logic next_clock_out;
   logic next_ice_select;
   logic next_ice_reset_n;
   logic next_scan_reset_n;
   logic next_sample;
   logic next_extest;
   logic next_bypass;
   logic [31:0] next_id;
   logic scan_active;

   always_comb begin
      // static design: the core clock may stop at any level
      next_core_clock = core_on_slow ? slow_clock : master_clock;
      // clock pin stays a slow clock copy through reset
      next_clock_out = (clock_out_as_gpio && !in_reset) ?
         clock_out_gpio_level : next_slow_clock;
      // both modes with the high select pin low pick emulation
      next_ice_select = (next_op_mode == RMS_MODE_OSC) ||
         (next_op_mode == RMS_MODE_EXT);
      // tap resets ignore the hardware reset entirely
      next_ice_reset_n = tap_reset_n || next_tap_choice_l;
      next_scan_reset_n = tap_reset_n || !next_tap_choice_l;
      // scan decode waits for the scan tap to leave reset
      scan_active = (op_mode == RMS_MODE_SCAN) && scan_reset_n;
      next_sample = scan_active && (scan_instr == INSTR_SAMPLE);
      next_extest = scan_active && (scan_instr == INSTR_EXTEST);
      // unknown codes fall back to bypass so the chain stays one bit
      next_bypass = scan_active && (scan_instr != INSTR_SAMPLE) &&
         (scan_instr != INSTR_EXTEST);
      // the emulator wants the core word, not a scan id
      next_id = next_ice_select ? CORE_ID_CODE : SCAN_ID_CODE;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         // values of a chip held in reset
         core_clock <= 1'b0;
         clock_out_pin <= 1'b0;
         pc_reset_n <= 1'b0;
         periph_reset_n <= 1'b0;
         fetch_from_zero <= 1'b1;
         ext_address_low <= 1'b1;
         periph_clock_en <= 1'b0;
         pio_all_input <= 1'b1;
         outputs_hiz <= 1'b0;
         ice_select <= 1'b1;
         ice_reset_n <= 1'b0;
         scan_reset_n <= 1'b0;
         scan_sample <= 1'b0;
         scan_extest <= 1'b0;
         scan_bypass <= 1'b0;
         tap_id_code <= CORE_ID_CODE;
      end else if (ce) begin
         // clock copies
         core_clock <= next_core_clock;
         clock_out_pin <= next_clock_out;
         // other core registers are left untouched on purpose
         pc_reset_n <= !in_reset;
         periph_reset_n <= !in_reset;
         fetch_from_zero <= in_reset;
         ext_address_low <= in_reset;
         periph_clock_en <= !in_reset;
         pio_all_input <= in_reset;
         outputs_hiz <= next_tristate_mode;
         // tap steering
         ice_select <= next_ice_select;
         ice_reset_n <= next_ice_reset_n;
         scan_reset_n <= next_scan_reset_n;
         scan_sample <= next_sample;
         scan_extest <= next_extest;
         scan_bypass <= next_bypass;
         tap_id_code <= next_id;
      end
   end
endmodule : rms_reset_mode_sequencer

// ---- inc/rms_pkg.sv ----
package rms_pkg;
   // operating modes, one-hot so a single bit answers "which mode"
   typedef enum logic [3:0] {
      RMS_MODE_OSC = 4'h1,
      RMS_MODE_SCAN = 4'h2,
      RMS_MODE_EXT = 4'h4,
      RMS_MODE_TEST = 4'h8
   } rms_mode_type;

   // sequencer states
   typedef enum logic [3:0] {
      RMS_ST_RUN = 4'h1,
      RMS_ST_HW = 4'h2,
      RMS_ST_SYNC = 4'h4,
      RMS_ST_WD = 4'h8
   } rms_state_type;

   // select pin codes, written as {op_select_lo, op_select_hi}
   localparam logic [1:0] SEL_NORMAL_OSC = 2'h0;
   localparam logic [1:0] SEL_SCAN = 2'h1;
   localparam logic [1:0] SEL_NORMAL_EXT = 2'h2;

   // slow-clock ticks of strap sampling window and watchdog hold
   localparam logic [3:0] STRAP_WINDOW = 4'hA;
   localparam logic [3:0] WD_HOLD_TICKS = 4'hA;
   localparam int STRAP_COUNT = 2;
   localparam int STRAP_BOOT = 0;
   localparam int STRAP_TRI = 1;

   // reset values of latched state
   localparam rms_mode_type MODE_RESET = RMS_MODE_OSC;
   localparam logic BOOT_WIDTH_RESET = 1'b1;
   localparam logic TRISTATE_RESET = 1'b0;
   localparam logic TAP_CHOICE_RESET = 1'b0;

   // tap instruction codes seen on scan_instr
   localparam logic [3:0] INSTR_EXTEST = 4'h0;
   localparam logic [3:0] INSTR_SAMPLE = 4'h1;
   localparam logic [3:0] INSTR_BYPASS = 4'hF;

   // identification words, values arbitrary
   localparam logic [31:0] CORE_ID_CODE = 32'h1234_5671;
   localparam logic [31:0] SCAN_ID_CODE = 32'h0ABC_DEF1;

   // decode of the two select pins
   function automatic rms_mode_type rms_decode(input logic sel_lo, input logic sel_hi);
      logic [1:0] code;
      code = {sel_lo, sel_hi};
      if (code == SEL_NORMAL_OSC) begin
         rms_decode = RMS_MODE_OSC;
      end else if (code == SEL_SCAN) begin
         rms_decode = RMS_MODE_SCAN;
      end else if (code == SEL_NORMAL_EXT) begin
         rms_decode = RMS_MODE_EXT;
      end else begin
         rms_decode = RMS_MODE_TEST;
      end
   endfunction : rms_decode
endpackage : rms_pkg

// ---- rtl/rms_strap_window.sv ----
`timescale 1ns/1ps
module rms_strap_window (
   input wire logic clock, // system clock
   input wire logic rstn, // synchronous reset, low
   input wire logic ce, // clock enable
   input wire logic slow_tick, // one cycle per slow clock rise
   input wire logic hold, // hardware reset pin held low
   input wire logic [rms_pkg::STRAP_COUNT-1:0] strap, // strap pin levels
   output logic window_full, // ten ticks seen in this reset
   output logic [rms_pkg::STRAP_COUNT-1:0] sample, // newest sample
   output logic [rms_pkg::STRAP_COUNT-1:0] stable // all window samples agree
);
   import rms_pkg::*;

   logic [3:0] count;
   logic [3:0] next_count;
   logic [STRAP_WINDOW-1:0] hist [STRAP_COUNT];
   logic [STRAP_WINDOW-1:0] next_hist [STRAP_COUNT];

   // tick counter saturates, cleared whenever the pin is high
   always_comb begin
      next_count = count;
      if (!hold) begin
         next_count = 4'h0;
      end else if (slow_tick && count != STRAP_WINDOW) begin
         next_count = count + 4'h1;
      end
   end
   assign window_full = (count == STRAP_WINDOW);

   // one history shifter per strap
   genvar g;
   generate
      for (g = 0; g < STRAP_COUNT; g++) begin : g_strap
         always_comb begin
            next_hist[g] = hist[g];
            if (hold && slow_tick) begin
               next_hist[g] = {hist[g][STRAP_WINDOW-2:0], strap[g]};
            end
         end
         assign sample[g] = hist[g][0];
         assign stable[g] = (hist[g] == '0) || (hist[g] == '1);
         always_ff @(posedge clock) begin
            if (!rstn) begin
               hist[g] <= '0;
            end else if (ce) begin
               hist[g] <= next_hist[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rstn) begin
         count <= 4'h0;
      end else if (ce) begin
         count <= next_count;
      end
   end
endmodule : rms_strap_window

// ---- verification/rms_board_model.sv ----
`timescale 1ns/1ps
// board oscillators; slow source is sped up so that reset windows stay short
module rms_board_model #(
   parameter int OSC_HALF = 4, // half period of on-chip oscillator, cycles
   parameter int PIN_HALF = 3 // half period of clock on oscillator pin, cycles
) (
   input wire logic clock, // system clock
   output logic osc_clock, // on-chip oscillator level
   output logic osc_input, // external clock on oscillator pin
   output logic master_clock // pll output level
);
   int n_osc = 0;
   int n_pin = 0;
   // free-running sources, moved well off the sampling edge to avoid races
   initial begin
      osc_clock = 1'b0;
      osc_input = 1'b0;
      master_clock = 1'b0;
   end
   always @(posedge clock) begin
      #20;
      master_clock = ~master_clock;
      n_osc = (n_osc + 1) % OSC_HALF;
      n_pin = (n_pin + 1) % PIN_HALF;
      if (n_osc == 0) begin
         osc_clock = ~osc_clock;
      end
      if (n_pin == 0) begin
         osc_input = ~osc_input;
      end
   end
endmodule : rms_board_model

// ---- verification/rms_seq_checker.sv ----
`timescale 1ns/1ps
module rms_seq_checker (
   input wire logic clock, // clk
   input wire logic rstn, // reset
   input wire logic ce, // enable
   input wire logic hw_reset_n, // pin
   input wire logic pc_reset_n, // out
   input wire logic periph_reset_n, // out
   input wire logic fetch_from_zero, // out
   input wire logic ext_address_low, // out
   input wire logic periph_clock_en, // out
   input wire logic pio_all_input, // out
   input wire logic slow_clock, // out
   input wire logic osc_input, // pin
   input wire rms_pkg::rms_mode_type op_mode, // out
   input wire logic ice_select, // out
   input wire logic [3:0] scan_instr, // in
   input wire logic scan_extest, // out
   input wire logic scan_sample, // out
   input wire logic tap_reset_n, // pin
   input wire logic ice_reset_n, // out
   input wire logic scan_reset_n, // out
   input wire logic tristate_mode, // out
   input wire logic outputs_hiz, // out
   input wire logic boot_width_8bit // out
);
   import rms_pkg::*;
   // one domain, so clock and disable are given once
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   a_reset_enters: assert property (ce && !hw_reset_n |=> !pc_reset_n && !periph_reset_n)
      else $error("reset outputs late after pin low");
   a_reset_outputs: assert property (!pc_reset_n |-> fetch_from_zero && ext_address_low && !periph_clock_en && pio_all_input)
      else $error("reset side outputs wrong");
   a_release_tick: assert property ($rose(pc_reset_n) |-> $past(slow_clock) && !$past(slow_clock, 2))
      else $error("release not on slow tick");
   a_bypass_clock: assert property ($past(pc_reset_n) && pc_reset_n && op_mode == RMS_MODE_EXT |-> slow_clock == $past(osc_input))
      else $error("slow clock not from pin");
   a_mode_hold: assert property ($changed(op_mode) |-> $rose(pc_reset_n))
      else $error("mode changed outside release");
   a_emul_select: assert property (ice_select == (op_mode == RMS_MODE_OSC || op_mode == RMS_MODE_EXT))
      else $error("emulation select wrong");
   a_scan_decode: assert property (scan_extest || scan_sample |-> $past(scan_instr) == (scan_extest ? INSTR_EXTEST : INSTR_SAMPLE))
      else $error("scan instruction decode wrong");
   a_tap_route: assert property ($past(rstn) && $past(tap_reset_n) |-> ice_reset_n && scan_reset_n)
      else $error("tap reset without tap pin");
   a_hiz_follow: assert property (outputs_hiz == tristate_mode)
      else $error("output float lags tristate");
   a_straps_kept: assert property (($changed(boot_width_8bit) || $changed(tristate_mode)) && $past(rstn, 2) |-> !$past(hw_reset_n) || !$past(hw_reset_n, 2) || !$past(hw_reset_n, 3) || !$past(hw_reset_n, 4))
      else $error("straps changed without pin reset");
endmodule : rms_seq_checker
bind rms_reset_mode_sequencer rms_seq_checker rms_seq_checker_inst (
   .clock(clock), .rstn(rstn), .ce(ce), .hw_reset_n(hw_reset_n), .pc_reset_n(pc_reset_n),
   .periph_reset_n(periph_reset_n), .fetch_from_zero(fetch_from_zero),
   .ext_address_low(ext_address_low), .periph_clock_en(periph_clock_en),
   .pio_all_input(pio_all_input), .slow_clock(slow_clock), .osc_input(osc_input),
   .op_mode(op_mode), .ice_select(ice_select), .scan_instr(scan_instr),
   .scan_extest(scan_extest), .scan_sample(scan_sample), .tap_reset_n(tap_reset_n),
   .ice_reset_n(ice_reset_n), .scan_reset_n(scan_reset_n), .tristate_mode(tristate_mode),
   .outputs_hiz(outputs_hiz), .boot_width_8bit(boot_width_8bit)
);

// ---- verification/test_reset_mode_sequencer.sv ----
`timescale 1ns/1ps
module test_reset_mode_sequencer;
   import rms_pkg::*;
   typedef struct packed {
      logic lo;
      logic hi;
      logic bws;
      logic trin;
      logic tc;
      rms_mode_type mode;
      logic ice;
   } rms_row_type;
   // pins and straps per row, beside the mode and selection they should give
   rms_row_type rows [4] = '{'{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, RMS_MODE_OSC, 1'b1},
      '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, RMS_MODE_SCAN, 1'b0},
      '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, RMS_MODE_EXT, 1'b1},
      '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, RMS_MODE_TEST, 1'b0}};
   logic [3:0] codes [4] = '{INSTR_EXTEST, INSTR_SAMPLE, INSTR_BYPASS, 4'h5};
   logic clock = 1'b0;
   logic rstn, ce, hw_reset_n, watchdog_reset, op_select_lo, op_select_hi, core_on_slow;
   logic clock_out_as_gpio, boot_width_select, tristate_request_n, tap_reset_n, tap_choice;
   logic [3:0] scan_instr;
   logic osc_clock, osc_input, master_clock, slow_clock, core_clock, clock_out_pin;
   logic pc_reset_n, periph_reset_n, fetch_from_zero, ext_address_low, periph_clock_en;
   logic pio_all_input, boot_width_8bit, tristate_mode, outputs_hiz, strap_unstable;
   logic reset_too_short, ice_select, ice_reset_n, scan_reset_n;
   logic scan_sample, scan_extest, scan_bypass, osc_seen, in_seen, mck_seen, slow_old, gpio_level;
   logic [31:0] tap_id_code;
   rms_mode_type op_mode, cur_mode;
   int n_mismatch = 0;
   int comparisons = 0;
   // 10 MHz clock; oscillator levels as the design sampled them
   always #50 clock = ~clock;
   always @(posedge clock) begin
      osc_seen <= osc_clock;
      in_seen <= osc_input;
      mck_seen <= master_clock;
      slow_old <= (cur_mode == RMS_MODE_EXT) ? in_seen : osc_seen;
   end
   rms_board_model rms_board_model_inst (.clock(clock), .osc_clock(osc_clock),
      .osc_input(osc_input), .master_clock(master_clock));
   rms_reset_mode_sequencer rms_reset_mode_sequencer_inst (.clock(clock), .rstn(rstn),
      .ce(ce), .hw_reset_n(hw_reset_n), .watchdog_reset(watchdog_reset),
      .op_select_lo(op_select_lo), .op_select_hi(op_select_hi), .osc_clock(osc_clock),
      .osc_input(osc_input), .master_clock(master_clock), .core_on_slow(core_on_slow),
      .clock_out_as_gpio(clock_out_as_gpio), .clock_out_gpio_level(gpio_level),
      .boot_width_select(boot_width_select), .tristate_request_n(tristate_request_n),
      .tap_reset_n(tap_reset_n), .tap_choice(tap_choice), .scan_instr(scan_instr),
      .slow_clock(slow_clock), .core_clock(core_clock), .clock_out_pin(clock_out_pin),
      .pc_reset_n(pc_reset_n), .periph_reset_n(periph_reset_n),
      .fetch_from_zero(fetch_from_zero), .ext_address_low(ext_address_low),
      .periph_clock_en(periph_clock_en), .pio_all_input(pio_all_input), .op_mode(op_mode),
      .boot_width_8bit(boot_width_8bit), .tristate_mode(tristate_mode),
      .outputs_hiz(outputs_hiz), .strap_unstable(strap_unstable),
      .reset_too_short(reset_too_short), .ice_select(ice_select), .ice_reset_n(ice_reset_n),
      .scan_reset_n(scan_reset_n), .scan_sample(scan_sample), .scan_extest(scan_extest),
      .scan_bypass(scan_bypass), .tap_id_code(tap_id_code));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   // inputs always move 10 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask : tick
   function automatic logic exp_slow();
      return (cur_mode == RMS_MODE_EXT) ? in_seen : osc_seen;
   endfunction : exp_slow
   task automatic wait_release(input int lim);
      for (int k = 0; k < lim && pc_reset_n !== 1'b1; k++) begin
         tick(1);
      end
      chk_bit(pc_reset_n, 1'b1);
   endtask : wait_release
   // full pin reset: both resets together, straps steady over the whole window
   task automatic pin_reset(input rms_row_type r, input logic wd);
      op_select_lo = r.lo;
      op_select_hi = r.hi;
      boot_width_select = r.bws;
      tristate_request_n = r.trin;
      tap_choice = r.tc;
      core_on_slow = r.lo;
      cur_mode = r.mode;
      clock_out_as_gpio = 1'b1;
      hw_reset_n = 1'b0;
      tap_reset_n = 1'b0;
      watchdog_reset = wd;
      tick(1);
      watchdog_reset = 1'b0;
      tap_reset_n = 1'b1;
      tick(100);
      chk_bit(fetch_from_zero, 1'b1);
      chk_bit(ext_address_low, 1'b1);
      chk_bit(periph_clock_en, 1'b0);
      chk_bit(pio_all_input, 1'b1);
      chk_bit(ice_reset_n & scan_reset_n, 1'b1);
      chk_bit(clock_out_pin, exp_slow());
      hw_reset_n = 1'b1;
      wait_release(40);
   endtask : pin_reset
   // hang guard, far beyond the expected run of about 800 cycles
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      {rstn, watchdog_reset, op_select_lo, op_select_hi, core_on_slow} = 5'h0;
      {clock_out_as_gpio, boot_width_select, tap_choice, gpio_level} = 4'h0;
      {ce, hw_reset_n, tristate_request_n, tap_reset_n} = 4'hF;
      scan_instr = 4'h0;
      cur_mode = RMS_MODE_OSC;
      tick(5);
      rstn = 1'b1;
      wait_release(40);
      for (int i = 0; i < 4; i++) begin
         pin_reset(rows[i], 1'b0);
         gpio_level = rows[i].bws;
         tick(2);
         chk_bit(clock_out_pin, rows[i].bws);
         clock_out_as_gpio = 1'b0;
         tick(2);
         chk_word({28'h0, op_mode}, {28'h0, rows[i].mode});
         chk_bit(ice_select, rows[i].ice);
         chk_word(tap_id_code, rows[i].ice ? CORE_ID_CODE : SCAN_ID_CODE);
         chk_bit(boot_width_8bit, rows[i].bws);
         chk_bit(outputs_hiz, ~rows[i].trin);
         chk_bit(clock_out_pin, exp_slow());
         chk_bit(slow_clock, exp_slow());
         chk_bit(core_clock, rows[i].lo ? slow_old : mck_seen);
      end
      // scan instructions, then a tap reset routed by the captured choice
      pin_reset(rows[1], 1'b0);
      foreach (codes[j]) begin
         scan_instr = codes[j];
         tick(2);
         chk_bit(scan_extest, codes[j] == INSTR_EXTEST);
         chk_bit(scan_sample, codes[j] == INSTR_SAMPLE);
         chk_bit(scan_bypass, codes[j] != INSTR_EXTEST && codes[j] != INSTR_SAMPLE);
      end
      tap_reset_n = 1'b0;
      tick(2);
      chk_bit(scan_reset_n, 1'b0);
      chk_bit(ice_reset_n, 1'b1);
      tap_reset_n = 1'b1;
      // watchdog with straps flipped: latched straps must survive
      {boot_width_select, tristate_request_n, watchdog_reset} = 3'h7;
      tick(1);
      watchdog_reset = 1'b0;
      tick(1);
      chk_bit(pc_reset_n, 1'b0);
      wait_release(120);
      chk_bit(boot_width_8bit, 1'b0);
      chk_bit(tristate_mode, 1'b1);
      // short pin reset with a strap moving inside the window
      hw_reset_n = 1'b0;
      tick(20);
      boot_width_select = 1'b0;
      tick(10);
      hw_reset_n = 1'b1;
      wait_release(40);
      chk_bit(strap_unstable, 1'b1);
      chk_bit(reset_too_short, 1'b1);
      // watchdog coinciding with the pin: straps are taken again
      pin_reset(rows[0], 1'b1);
      chk_bit(boot_width_8bit, 1'b1);
      chk_bit(tristate_mode, 1'b0);
      chk_bit(strap_unstable, 1'b0);
      chk_bit(reset_too_short, 1'b0);
      // synchronous reset in mid-run
      rstn = 1'b0;
      tick(2);
      chk_bit(pc_reset_n, 1'b0);
      chk_word({28'h0, op_mode}, {28'h0, MODE_RESET});
      rstn = 1'b1;
      wait_release(40);
      give_verdict();
   end
endmodule : test_reset_mode_sequencer
